// ### rtl/irq_flag_pkg.sv
// Constants and types of the radio interrupt flag and mask logic.
// Assumes a 50 MHz system clock; the host link has its own serial clock.
package irq_flag_pkg;

	// Bit positions in the flag byte and in the mask byte
	localparam int BIT_DAV  = 7;
	localparam int BIT_SYNC = 5;
	localparam int BIT_IFC  = 4;
	localparam int BIT_LEV  = 3;
	localparam int BIT_FRR  = 1;
	localparam int BIT_BAND = 0;

	// Bits that exist; the test bit and bit 2 read as zero
	localparam logic [7:0] FLAG_USED  = 8'hbb;
	localparam logic [7:0] FLAGS_RST  = 8'h00;
	localparam logic [7:0] MASKS_RST  = 8'h00;
	localparam logic [7:0] KEEP_SYNC  = 8'h20;

	// Decoder modes
	localparam logic [1:0] MODE_STD  = 2'h0;
	localparam logic [1:0] MODE_FAST = 2'h1;
	localparam logic [1:0] MODE_RED  = 2'h2;

	// Level thresholds per search level setting
	localparam logic [3:0] SSL_THR [0:3] = '{4'h3, 4'h5, 4'h7, 4'ha};
	localparam logic [1:0] SSL_NONE      = 2'h3;
	localparam logic [3:0] HYST_SMALL    = 4'h1;
	localparam logic [3:0] HYST_LARGE    = 4'h2;

	// Times in their own units, then cycles at the system clock
	localparam int CLK_MHZ         = 50;
	localparam int IF_DELAY_US_X10 = 156000;
	localparam int LEVEL_TICK_US   = 500;
	localparam int IRQ_LOW_MAX_US  = 1000;
	localparam int IF_DELAY_CYC    = IF_DELAY_US_X10 * CLK_MHZ / 10;
	localparam int LEVEL_TICK_CYC  = LEVEL_TICK_US * CLK_MHZ;
	localparam int IRQ_LOW_CYC     = IRQ_LOW_MAX_US * CLK_MHZ;
	localparam int CNT_W           = 20;

	typedef enum logic [2:0] {
		IRQ_ARMED = 3'b001,
		IRQ_LOW   = 3'b010,
		IRQ_SPENT = 3'b100
	} irq_state_t;

	// Link side: window, bytes seen, toggles and held mask data
	typedef struct packed {
		logic       win;
		logic       flag_rd;
		logic       mask_rd;
		logic       clr_flag_tg;
		logic       clr_all_tg;
		logic       mask_wr_tg;
		logic       blk_rd_tg;
		logic [7:0] mask_data;
	} link_state_t;

	// System side state
	typedef struct packed {
		logic [1:0]       win_s;
		logic [1:0]       cf_s;
		logic [1:0]       ca_s;
		logic [1:0]       mw_s;
		logic [1:0]       br_s;
		logic             win_d;
		logic             cf_d;
		logic             ca_d;
		logic             mw_d;
		logic             br_d;
		logic [7:0]       flags;
		logic [7:0]       masks;
		logic [7:0]       pend;
		irq_state_t       irq;
		logic             read_seen;
		logic [CNT_W-1:0] irq_cnt;
		logic             busy;
		logic             if_run;
		logic [CNT_W-1:0] if_cnt;
		logic             post_algo;
		logic             ssl_none;
		logic [CNT_W-1:0] lvl_cnt;
		logic             dav_half;
		logic             idle;
		logic             restart;
	} sys_state_t;

endpackage : irq_flag_pkg

// ### rtl/radio_interrupt_flag_logic.sv
// Interrupt flag, mask and one-shot line logic of the radio chip.
// Assumes a serial engine on the link clock that reports byte events,
// and tuner and decoder logic on the system clock that reports events.
//
// Behaviour
// - Reading flag and mask bytes clears flags and masks except sync enable.
// - Outside window, event sets flag, may pull line.
// - I2C events in window set flag afterwards.
// - Flag-only read clears flags; both read clears flags and masks but sync enable.
// - SPI window ends first falling edge, CS high.
// - Mask write fires interrupt for already set flags.
// - Reading flag and mask releases the line.
// - One-shot blocked until read then mask write.
// - Line low never exceeds its maximum time.
// - Search: two good blocks or fast A/C'.
// - Synced: data flag per block (every second block in reduced mode), or sync loss.
// - Block byte reads clear data flag.
// - Masked sync loss: flag, interrupt, decoder idle.
// - Unmasked sync loss restarts search silently.
// - Mask read clears sync flag, keeps its enable.
// - Wrong IF count during algorithms sets flag.
// - Algorithm finish sets tune-done flag.
// - IF checks run 15.6 ms after tune done.
// - IF flag clears on read or tune start.
// - Algorithm level below search threshold sets flag.
// - Afterwards compare hysteresis threshold every 500 us.
// - Level setting 3 disables level flag afterwards.
// - Mask bit one lets flag pull the line.
`timescale 1ns/100ps
module radio_interrupt_flag_logic
	import irq_flag_pkg::*;
#(
	parameter int P_IF_DELAY_CYC   = IF_DELAY_CYC,
	parameter int P_LEVEL_TICK_CYC = LEVEL_TICK_CYC,
	parameter int P_IRQ_LOW_CYC    = IRQ_LOW_CYC
) (
	input  wire logic       i_clk_sys,
	input  wire logic       i_resetn,
	input  wire logic       i_clk_link,
	input  wire logic       i_lk_spi_mode,
	input  wire logic       i_lk_read_start,
	input  wire logic       i_lk_flag_sent,
	input  wire logic       i_lk_mask_sent,
	input  wire logic       i_lk_read_end,
	input  wire logic       i_lk_cs,
	input  wire logic       i_lk_mask_wr,
	input  wire logic [7:0] i_lk_mask_wdata,
	input  wire logic       i_lk_block_rd,
	input  wire logic       i_spi_mode,
	input  wire logic [7:0] i_cause_present,
	input  wire logic       i_block_valid,
	input  wire logic       i_block_is_ac,
	input  wire logic       i_block_seq_ok,
	input  wire logic [5:0] i_bad_block_count,
	input  wire logic [5:0] i_bad_blocks_lose_limit,
	input  wire logic [1:0] i_decode_mode,
	input  wire logic       i_synced,
	input  wire logic       i_sync_lost,
	input  wire logic       i_new_sync_search,
	input  wire logic       i_tune_start,
	input  wire logic       i_tune_done,
	input  wire logic       i_band_limit,
	input  wire logic       i_if_check,
	input  wire logic       i_if_ok,
	input  wire logic       i_level_sample,
	input  wire logic [3:0] i_level,
	input  wire logic [1:0] i_search_level_threshold,
	input  wire logic       i_hysteresis_select,
	output logic [7:0]      o_flag_byte,
	output logic [7:0]      o_mask_byte,
	output logic            o_irq_line_n_o,
	output logic            o_irq_line_n_oe,
	output logic            o_decoder_idle,
	output logic            o_restart_sync
);

	link_state_t l_r;
	link_state_t l_nxt;
	sys_state_t  s_r;
	sys_state_t  s_nxt;

	// Link side runs on the falling serial clock edge
	logic spi_end;
	logic win_end_lk;

	always_comb begin
		l_nxt      = l_r;
		spi_end    = l_r.win & i_lk_spi_mode & i_lk_cs;
		win_end_lk = spi_end | (l_r.win & ~i_lk_spi_mode & i_lk_read_end);
		if (i_lk_read_start) begin
			l_nxt.win     = 1'b1;
			l_nxt.flag_rd = 1'b0;
			l_nxt.mask_rd = 1'b0;
		end
		if (l_r.win & i_lk_flag_sent) begin
			l_nxt.flag_rd = 1'b1;
		end
		if (l_r.win & i_lk_mask_sent) begin
			l_nxt.mask_rd = 1'b1;
		end
		if (win_end_lk) begin
			l_nxt.win = 1'b0;
			if (l_r.mask_rd | i_lk_mask_sent) begin
				l_nxt.clr_all_tg = ~l_r.clr_all_tg;
			end else if (l_r.flag_rd) begin
				l_nxt.clr_flag_tg = ~l_r.clr_flag_tg;
			end
		end
		// Data is held until the next write, so the toggle may cross alone
		if (i_lk_mask_wr) begin
			l_nxt.mask_data  = i_lk_mask_wdata;
			l_nxt.mask_wr_tg = ~l_r.mask_wr_tg;
		end
		if (i_lk_block_rd) begin
			l_nxt.blk_rd_tg = ~l_r.blk_rd_tg;
		end
	end

	always_ff @(negedge i_clk_link or negedge i_resetn) begin
		if (!i_resetn) begin
			l_r <= '0;
		end else begin
			l_r <= l_nxt;
		end
	end

	// System side
	logic       win;
	logic       win_end;
	logic       clr_flag;
	logic       clr_all;
	logic       mask_wr;
	logic       blk_rd;
	logic [7:0] ev;
	logic [7:0] set_v;
	logic [7:0] clr_v;
	logic [7:0] enabled;
	logic [3:0] hyst_thr;
	logic       lvl_tick;
	logic       dav_sync;
	logic       dav_search;

	always_comb begin
		s_nxt         = s_r;
		s_nxt.restart = 1'b0;
		s_nxt.win_s   = {s_r.win_s[0], l_r.win};
		s_nxt.cf_s    = {s_r.cf_s[0], l_r.clr_flag_tg};
		s_nxt.ca_s    = {s_r.ca_s[0], l_r.clr_all_tg};
		s_nxt.mw_s    = {s_r.mw_s[0], l_r.mask_wr_tg};
		s_nxt.br_s    = {s_r.br_s[0], l_r.blk_rd_tg};
		s_nxt.win_d   = s_r.win_s[1];
		s_nxt.cf_d    = s_r.cf_s[1];
		s_nxt.ca_d    = s_r.ca_s[1];
		s_nxt.mw_d    = s_r.mw_s[1];
		s_nxt.br_d    = s_r.br_s[1];
		win      = s_r.win_s[1];
		win_end  = s_r.win_d & ~s_r.win_s[1];
		clr_flag = s_r.cf_s[1] ^ s_r.cf_d;
		clr_all  = s_r.ca_s[1] ^ s_r.ca_d;
		mask_wr  = s_r.mw_s[1] ^ s_r.mw_d;
		blk_rd   = s_r.br_s[1] ^ s_r.br_d;

		// Data available events
		dav_search = i_block_valid & ~i_synced &
			((i_block_seq_ok &
			(i_bad_block_count < i_bad_blocks_lose_limit)) |
			((i_decode_mode == MODE_FAST) & i_block_is_ac));
		dav_sync = i_block_valid & i_synced &
			((i_decode_mode != MODE_RED) | s_r.dav_half);
		if (!i_synced) begin
			s_nxt.dav_half = 1'b0;
		end else if (i_block_valid & (i_decode_mode == MODE_RED)) begin
			s_nxt.dav_half = ~s_r.dav_half;
		end

		// Sync loss handling
		if (i_sync_lost & s_r.masks[BIT_SYNC]) begin
			s_nxt.idle = 1'b1;
		end else if (i_new_sync_search) begin
			s_nxt.idle = 1'b0;
		end
		s_nxt.restart = i_sync_lost & ~s_r.masks[BIT_SYNC];

		// Tuning algorithm tracking
		if (i_tune_start) begin
			s_nxt.busy      = 1'b1;
			s_nxt.if_run    = 1'b0;
			s_nxt.post_algo = 1'b0;
			s_nxt.ssl_none  = (i_search_level_threshold == SSL_NONE);
		end else if (i_tune_done) begin
			s_nxt.busy      = 1'b0;
			s_nxt.post_algo = 1'b1;
			s_nxt.if_cnt    = CNT_W'(P_IF_DELAY_CYC - 1);
			s_nxt.lvl_cnt   = CNT_W'(P_LEVEL_TICK_CYC - 1);
		end
		if (s_r.post_algo & ~s_r.if_run & ~i_tune_done) begin
			if (s_r.if_cnt == '0) begin
				s_nxt.if_run = 1'b1;
			end else begin
				s_nxt.if_cnt = s_r.if_cnt - 1'b1;
			end
		end
		lvl_tick = s_r.post_algo & (s_r.lvl_cnt == '0);
		if (s_r.post_algo & ~i_tune_done) begin
			s_nxt.lvl_cnt = lvl_tick ? CNT_W'(P_LEVEL_TICK_CYC - 1) :
				s_r.lvl_cnt - 1'b1;
		end
		// Hysteresis below the search threshold, held at zero
		hyst_thr = SSL_THR[i_search_level_threshold];
		if (i_hysteresis_select) begin
			hyst_thr = (hyst_thr > HYST_LARGE) ? hyst_thr - HYST_LARGE :
				4'h0;
		end else begin
			hyst_thr = (hyst_thr > HYST_SMALL) ? hyst_thr - HYST_SMALL :
				4'h0;
		end
		if (s_r.ssl_none) begin
			hyst_thr = 4'h0;
		end

		// Raw events this cycle
		ev            = 8'h00;
		ev[BIT_DAV]   = dav_search | dav_sync |
			(i_sync_lost & ~s_r.masks[BIT_SYNC]);
		ev[BIT_SYNC]  = i_sync_lost & s_r.masks[BIT_SYNC];
		ev[BIT_IFC]   = i_if_check & ~i_if_ok &
			(s_r.busy | s_r.if_run);
		ev[BIT_LEV]   = (s_r.busy & i_level_sample &
			(i_level < SSL_THR[i_search_level_threshold])) |
			(lvl_tick & (i_level < hyst_thr));
		ev[BIT_FRR]   = i_tune_done;
		ev[BIT_BAND]  = i_band_limit;

		// Blocking window holds events until the window closes
		set_v = win ? 8'h00 : ev;
		if (win) begin
			s_nxt.pend = s_r.pend | ev;
		end
		if (win_end) begin
			s_nxt.pend = 8'h00;
			set_v = set_v | (i_spi_mode ?
				(s_r.pend & i_cause_present) : s_r.pend);
		end

		// Clears; a set in the same cycle wins
		clr_v = 8'h00;
		if (clr_flag | clr_all) begin
			clr_v = 8'hff;
		end
		if (blk_rd) begin
			clr_v[BIT_DAV] = 1'b1;
		end
		if (i_tune_start) begin
			clr_v[BIT_IFC] = 1'b1;
			clr_v[BIT_LEV] = 1'b1;
		end
		s_nxt.flags = ((s_r.flags & ~clr_v) | set_v) & FLAG_USED;

		// Masks: sync loss enable survives the read
		if (clr_all) begin
			s_nxt.masks     = s_r.masks & KEEP_SYNC;
			s_nxt.read_seen = 1'b1;
		end
		if (mask_wr) begin
			s_nxt.masks = l_r.mask_data & FLAG_USED;
		end

		// One-shot line driver
		enabled = s_r.flags & s_r.masks;
		case (s_r.irq)
			IRQ_ARMED: begin
				// A read landing now wins; firing would outlast it
				if ((|enabled) & ~clr_all) begin
					s_nxt.irq       = IRQ_LOW;
					s_nxt.irq_cnt   = CNT_W'(P_IRQ_LOW_CYC - 1);
					s_nxt.read_seen = 1'b0;
				end
			end
			IRQ_LOW: begin
				s_nxt.irq_cnt = s_r.irq_cnt - 1'b1;
				if (clr_all) begin
					s_nxt.irq = IRQ_SPENT;
				end else if (s_r.irq_cnt == '0) begin
					s_nxt.irq = IRQ_SPENT;
				end
			end
			IRQ_SPENT: begin
				// Repeats stay silent until read and rewrite
				if (mask_wr & (s_r.read_seen | clr_all)) begin
					s_nxt.irq       = IRQ_ARMED;
					s_nxt.read_seen = 1'b0;
				end
			end
			default: begin
				s_nxt.irq = IRQ_ARMED;
			end
		endcase
	end

	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			s_r       <= '0;
			s_r.flags <= FLAGS_RST;
			s_r.masks <= MASKS_RST;
			s_r.irq   <= IRQ_ARMED;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign o_flag_byte     = s_r.flags;
	assign o_mask_byte     = s_r.masks;
	assign o_irq_line_n_o  = 1'b0;
	assign o_irq_line_n_oe = (s_r.irq == IRQ_LOW);
	assign o_decoder_idle  = s_r.idle;
	assign o_restart_sync  = s_r.restart;

	// Helper: length of the current low pulse
	logic [CNT_W-1:0] low_len_r;
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			low_len_r <= '0;
		end else begin
			low_len_r <= o_irq_line_n_oe ? low_len_r + 1'b1 : '0;
		end
	end

	sequence s_write_with_flag;
		mask_wr && (s_r.irq == IRQ_ARMED) && |(s_r.flags & l_r.mask_data);
	endsequence
	sequence s_line_low;
		o_irq_line_n_oe;
	endsequence

	flag_set_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		!win && !win_end && i_tune_done |=> s_r.flags[BIT_FRR])
		else $error("event outside window did not set flag");
	block_hold_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		win && i_tune_done && !s_r.flags[BIT_FRR] |=>
		!s_r.flags[BIT_FRR])
		else $error("event inside window set flag early");
	mask_clear_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		clr_all && !mask_wr |=> (s_r.masks & ~KEEP_SYNC) == 8'h00)
		else $error("masks not cleared by read");
	sync_keep_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		clr_all && !mask_wr |=>
		s_r.masks[BIT_SYNC] == $past(s_r.masks[BIT_SYNC]))
		else $error("sync loss enable changed by read");
	line_release_a: assert property (@(posedge i_clk_sys)
		disable iff (!i_resetn)
		clr_all |=> !o_irq_line_n_oe)
		else $error("line not released after read");
	one_shot_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		(s_r.irq == IRQ_SPENT) && !mask_wr |=> !o_irq_line_n_oe)
		else $error("line pulled again without rewrite");
	pulse_max_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		low_len_r <= CNT_W'(P_IRQ_LOW_CYC))
		else $error("line low too long");
	rearm_fire_a: assert property (@(posedge i_clk_sys)
		disable iff (!i_resetn)
		s_write_with_flag |-> ##2 s_line_low)
		else $error("mask write did not fire interrupt");
	idle_set_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		!win && i_sync_lost && s_r.masks[BIT_SYNC] |=>
		o_decoder_idle && s_r.flags[BIT_SYNC])
		else $error("masked sync loss did not idle decoder");
	auto_restart_a: assert property (@(posedge i_clk_sys)
		disable iff (!i_resetn)
		i_sync_lost && !s_r.masks[BIT_SYNC] |=>
		o_restart_sync && !s_r.flags[BIT_SYNC])
		else $error("unmasked sync loss did not restart");
	dav_clear_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		blk_rd && !ev[BIT_DAV] && !win_end |=> !s_r.flags[BIT_DAV])
		else $error("block read did not clear data flag");
	if_clear_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		i_tune_start && !win_end && !ev[BIT_IFC] && !ev[BIT_LEV] |=>
		!s_r.flags[BIT_IFC] && !s_r.flags[BIT_LEV])
		else $error("tune start did not clear flags");
	spi_end_a: assert property (@(negedge i_clk_link) disable iff (!i_resetn)
		l_r.win && i_lk_spi_mode && i_lk_cs && !i_lk_read_start |=>
		!l_r.win)
		else $error("spi window did not end");

endmodule : radio_interrupt_flag_logic

// ### verification/host_link_model.sv
// Host side of the control link: plays the byte events that the serial
// engine reports while the host reads or writes the interrupt bytes.
// Assumes the bench picks the link mode before a frame starts.
`timescale 1ns/100ps
module host_link_model (
	input  wire logic  i_spi,
	output logic       o_clk_link,
	output logic       o_read_start,
	output logic       o_flag_sent,
	output logic       o_mask_sent,
	output logic       o_read_end,
	output logic       o_cs,
	output logic       o_mask_wr,
	output logic [7:0] o_mask_wdata,
	output logic       o_block_rd
);
	// Link clock stands still low between frames
	initial begin
		{o_clk_link, o_read_start, o_flag_sent, o_mask_sent} = '0;
		{o_read_end, o_mask_wr, o_block_rd} = '0;
		o_cs = 1'b1;
		o_mask_wdata = 8'h00;
	end

	// Lines change with the rise, the device samples on the fall
	task automatic step(input int n);
		repeat (n) begin
			o_clk_link = 1'b1;
			#15;
			o_clk_link = 1'b0;
			#15;
		end
	endtask : step

	// Gaps stand for the eight bit times of each byte
	task automatic read_ints(input logic both);
		o_cs = ~i_spi;
		step(2);
		o_read_start = 1'b1;
		step(1);
		o_read_start = 1'b0;
		step(8);
		o_flag_sent = 1'b1;
		step(1);
		o_flag_sent = 1'b0;
		step(8);
		if (both) begin
			o_mask_sent = 1'b1;
			step(1);
			o_mask_sent = 1'b0;
			step(8);
		end
		if (i_spi)
			o_cs = 1'b1;
		else
			o_read_end = 1'b1;
		step(1);
		o_read_end = 1'b0;
		step(2);
	endtask : read_ints

	// Data is left standing; the device keeps its own copy
	task automatic write_mask(input logic [7:0] d);
		o_cs = ~i_spi;
		o_mask_wdata = d;
		o_mask_wr = 1'b1;
		step(1);
		o_mask_wr = 1'b0;
		o_cs = 1'b1;
		step(2);
	endtask : write_mask

	task automatic block_read;
		o_block_rd = 1'b1;
		step(1);
		o_block_rd = 1'b0;
		step(2);
	endtask : block_read
endmodule : host_link_model

// ### verification/test_radio_interrupt_flag_logic.sv
// Bench of the interrupt flag logic: one task per scenario.
// Assumes the host link model above and shortened time parameters.
`timescale 1ns/100ps
`define CHK(got, exp, msg) begin checked++; if ((got) !== (exp)) begin \
	fail_count++; $display("mismatch at %0t: %s", $time, msg); end end
module test_radio_interrupt_flag_logic;
	import irq_flag_pkg::*;
	localparam int IFD = 50, TICK = 20, LOWC = 200;
	localparam logic [7:0] EV_DONE = 8'h01, EV_START = 8'h02,
		EV_BAND = 8'h04, EV_IFC = 8'h08, EV_LVL = 8'h10, EV_LOST = 8'h20,
		EV_BLK = 8'h40, EV_NEWS = 8'h80;
	logic       i_clk_sys = 0, i_resetn = 0, i_spi_mode, i_if_ok;
	logic       i_block_is_ac, i_block_seq_ok, i_synced;
	logic       i_hysteresis_select;
	logic [7:0] i_cause_present, ev = '0;
	logic [5:0] i_bad_block_count, i_bad_blocks_lose_limit;
	logic [1:0] i_decode_mode, i_search_level_threshold;
	logic [3:0] i_level;
	logic       i_tune_done, i_tune_start, i_band_limit, i_if_check;
	logic       i_level_sample, i_sync_lost, i_block_valid, i_new_sync_search;
	logic       i_clk_link, i_lk_spi_mode, i_lk_read_start, i_lk_flag_sent;
	logic       i_lk_mask_sent, i_lk_read_end, i_lk_cs, i_lk_mask_wr;
	logic       i_lk_block_rd;
	logic [7:0] i_lk_mask_wdata, o_flag_byte, o_mask_byte;
	logic       o_irq_line_n_o, o_irq_line_n_oe, o_decoder_idle, o_restart_sync;
	int         fail_count = 0, checked = 0, waited, restarts = 0;

	assign {i_new_sync_search, i_block_valid, i_sync_lost, i_level_sample,
		i_if_check, i_band_limit, i_tune_start, i_tune_done} = ev;
	assign i_lk_spi_mode = i_spi_mode;

	initial begin
		forever #10 i_clk_sys = ~i_clk_sys;
	end
	always @(posedge i_clk_sys) begin
		if (o_restart_sync === 1'b1)
			restarts++;
	end

	radio_interrupt_flag_logic #(.P_IF_DELAY_CYC(IFD),
		.P_LEVEL_TICK_CYC(TICK), .P_IRQ_LOW_CYC(LOWC)) dut_u (
		.i_clk_sys, .i_resetn, .i_clk_link, .i_lk_spi_mode, .i_lk_read_start,
		.i_lk_flag_sent, .i_lk_mask_sent, .i_lk_read_end, .i_lk_cs,
		.i_lk_mask_wr, .i_lk_mask_wdata, .i_lk_block_rd, .i_spi_mode,
		.i_cause_present, .i_block_valid, .i_block_is_ac, .i_block_seq_ok,
		.i_bad_block_count, .i_bad_blocks_lose_limit, .i_decode_mode,
		.i_synced, .i_sync_lost, .i_new_sync_search, .i_tune_start,
		.i_tune_done, .i_band_limit, .i_if_check, .i_if_ok, .i_level_sample,
		.i_level, .i_search_level_threshold, .i_hysteresis_select,
		.o_flag_byte, .o_mask_byte, .o_irq_line_n_o, .o_irq_line_n_oe,
		.o_decoder_idle, .o_restart_sync);

	host_link_model host_u (.i_spi(i_spi_mode), .o_clk_link(i_clk_link),
		.o_read_start(i_lk_read_start), .o_flag_sent(i_lk_flag_sent),
		.o_mask_sent(i_lk_mask_sent), .o_read_end(i_lk_read_end),
		.o_cs(i_lk_cs), .o_mask_wr(i_lk_mask_wr),
		.o_mask_wdata(i_lk_mask_wdata), .o_block_rd(i_lk_block_rd));

	task automatic summarize;
		$display("checked %0d, fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : summarize

	task automatic settle(input int n);
		repeat (n) @(posedge i_clk_sys);
		#1;
	endtask : settle

	task automatic pulse(input logic [7:0] m);
		@(posedge i_clk_sys) ev <= m;
		@(posedge i_clk_sys) ev <= '0;
	endtask : pulse

	// Bounded wait for the line; running out ends the run
	task automatic wait_oe(input logic lv, input int lim);
		waited = 0;
		checked++;
		while (o_irq_line_n_oe !== lv) begin
			settle(1);
			waited++;
			if (waited > lim) begin
				fail_count++;
				$display("mismatch at %0t: line wait ran out", $time);
				summarize();
			end
		end
	endtask : wait_oe

	task automatic t_irq;
		pulse(EV_DONE);
		settle(1);
		`CHK(o_flag_byte, 8'h02, "tune done flag")
		settle(5);
		`CHK(o_irq_line_n_oe, 1'b0, "line pulled without enable")
		`CHK(o_irq_line_n_o, 1'b0, "line driven high")
		host_u.write_mask(8'h02);
		wait_oe(1'b1, 12);
		pulse(EV_DONE);
		wait_oe(1'b0, LOWC + 2);
		pulse(EV_DONE);
		settle(5);
		`CHK(o_irq_line_n_oe, 1'b0, "repeat event fired again")
		$display("t_irq done");
	endtask : t_irq

	task automatic t_read;
		pulse(EV_BAND);
		host_u.read_ints(1'b0);
		settle(8);
		`CHK({o_flag_byte, o_mask_byte}, 16'h0002, "flag only read")
		pulse(EV_DONE);
		host_u.read_ints(1'b1);
		settle(8);
		`CHK({o_flag_byte, o_mask_byte}, 16'h0000, "full read")
		host_u.write_mask(8'h22);
		settle(8);
		pulse(EV_DONE);
		settle(1);
		`CHK(o_irq_line_n_oe, 1'b1, "event did not pull line")
		host_u.read_ints(1'b1);
		settle(8);
		`CHK(o_irq_line_n_oe, 1'b0, "line kept after read")
		`CHK(o_mask_byte, 8'h20, "sync enable lost on read")
		$display("t_read done");
	endtask : t_read

	task automatic t_sync;
		int r0;
		host_u.write_mask(8'h20);
		settle(8);
		@(posedge i_clk_sys) i_synced <= 1'b1;
		pulse(EV_LOST);
		settle(2);
		`CHK({o_flag_byte[BIT_SYNC], o_decoder_idle}, 2'h3, "masked loss")
		`CHK(o_irq_line_n_oe, 1'b1, "masked loss quiet")
		pulse(EV_NEWS);
		settle(2);
		`CHK(o_decoder_idle, 1'b0, "idle kept after new search")
		host_u.read_ints(1'b1);
		settle(8);
		`CHK({o_flag_byte, o_mask_byte}, 16'h0020, "sync flag read")
		host_u.write_mask(8'h00);
		settle(8);
		r0 = restarts;
		pulse(EV_LOST);
		settle(4);
		`CHK(restarts - r0, 1, "search not restarted")
		`CHK(o_flag_byte[BIT_SYNC:BIT_SYNC], 1'b0, "sync flag set")
		`CHK(o_flag_byte[BIT_DAV], 1'b1, "loss data flag")
		`CHK(o_irq_line_n_oe, 1'b0, "unmasked loss pulled line")
		$display("t_sync done");
	endtask : t_sync

	task automatic blk(input logic [1:0] m, input logic s, ac, sq, clr,
		input logic [5:0] bb, input logic exp);
		if (clr) begin
			host_u.block_read();
			settle(8);
			`CHK(o_flag_byte[BIT_DAV], 1'b0, "block read kept flag")
		end
		@(posedge i_clk_sys) begin
			i_decode_mode <= m;
			i_synced <= s;
			i_block_is_ac <= ac;
			i_block_seq_ok <= sq;
			i_bad_block_count <= bb;
		end
		pulse(EV_BLK);
		settle(1);
		`CHK(o_flag_byte[BIT_DAV], exp, "data flag after block")
	endtask : blk

	task automatic t_blk;
		blk(MODE_RED, 1'b1, 1'b0, 1'b1, 1'b1, 6'h00, 1'b0);
		blk(MODE_RED, 1'b1, 1'b0, 1'b1, 1'b0, 6'h00, 1'b1);
		blk(MODE_STD, 1'b1, 1'b0, 1'b1, 1'b1, 6'h00, 1'b1);
		blk(MODE_STD, 1'b0, 1'b0, 1'b1, 1'b1, 6'h04, 1'b0);
		blk(MODE_STD, 1'b0, 1'b0, 1'b1, 1'b0, 6'h03, 1'b1);
		@(posedge i_clk_sys) i_bad_blocks_lose_limit <= 6'h03;
		blk(MODE_STD, 1'b0, 1'b0, 1'b1, 1'b1, 6'h03, 1'b0);
		blk(MODE_FAST, 1'b0, 1'b1, 1'b0, 1'b1, 6'h00, 1'b1);
		$display("t_blk done");
	endtask : t_blk

	task automatic t_ifc;
		@(posedge i_clk_sys) i_if_ok <= 1'b0;
		pulse(EV_START);
		pulse(EV_IFC);
		settle(1);
		`CHK(o_flag_byte[BIT_IFC], 1'b1, "bad count in search")
		pulse(EV_START);
		settle(1);
		`CHK(o_flag_byte[BIT_IFC], 1'b0, "tune start kept flag")
		pulse(EV_IFC);
		host_u.read_ints(1'b1);
		settle(8);
		`CHK(o_flag_byte[BIT_IFC], 1'b0, "read kept count flag")
		pulse(EV_START);
		pulse(EV_DONE);
		pulse(EV_IFC);
		settle(1);
		`CHK(o_flag_byte[BIT_IFC], 1'b0, "check ran too early")
		settle(IFD);
		pulse(EV_IFC);
		settle(1);
		`CHK(o_flag_byte[BIT_IFC], 1'b1, "late check ignored")
		@(posedge i_clk_sys) i_if_ok <= 1'b1;
		$display("t_ifc done");
	endtask : t_ifc

	task automatic t_lev;
		@(posedge i_clk_sys) i_search_level_threshold <= 2'h1;
		i_level <= 4'h4;
		pulse(EV_START);
		pulse(EV_LVL);
		settle(1);
		`CHK(o_flag_byte[BIT_LEV], 1'b1, "low level in search")
		pulse(EV_START);
		settle(1);
		`CHK(o_flag_byte[BIT_LEV], 1'b0, "tune start kept level")
		@(posedge i_clk_sys) i_level <= 4'h5;
		pulse(EV_LVL);
		settle(1);
		`CHK(o_flag_byte[BIT_LEV], 1'b0, "level at threshold")
		@(posedge i_clk_sys) i_level <= 4'h0;
		pulse(EV_DONE);
		settle(2 * TICK + 2);
		`CHK(o_flag_byte[BIT_LEV], 1'b1, "periodic check idle")
		@(posedge i_clk_sys) i_level <= 4'hf;
		host_u.read_ints(1'b1);
		settle(2 * TICK);
		`CHK(o_flag_byte[BIT_LEV], 1'b0, "high level flagged")
		// Setting 1: large hysteresis puts the threshold at 3, small at 4
		@(posedge i_clk_sys) begin
			i_hysteresis_select <= 1'b1;
			i_level <= 4'h3;
		end
		settle(2 * TICK);
		`CHK(o_flag_byte[BIT_LEV], 1'b0, "large hysteresis flagged")
		@(posedge i_clk_sys) i_hysteresis_select <= 1'b0;
		settle(2 * TICK);
		`CHK(o_flag_byte[BIT_LEV], 1'b1, "small hysteresis missed")
		@(posedge i_clk_sys) i_level <= 4'hf;
		@(posedge i_clk_sys) i_search_level_threshold <= SSL_NONE;
		pulse(EV_START);
		pulse(EV_DONE);
		@(posedge i_clk_sys) i_level <= 4'h0;
		settle(3 * TICK);
		`CHK(o_flag_byte[BIT_LEV], 1'b0, "level flag with setting 3")
		$display("t_lev done");
	endtask : t_lev

	// Event lands mid read; the flag is checked against exp after the window closes
	task automatic win(input logic s, c, exp);
		@(posedge i_clk_sys) i_spi_mode <= s;
		i_cause_present <= {8{c}};
		settle(2);
		fork
			host_u.read_ints(1'b1);
			begin
				settle(30);
				pulse(EV_BAND);
			end
		join
		settle(8);
		`CHK(o_flag_byte[BIT_BAND], exp, "held event")
	endtask : win

	initial begin
		{i_spi_mode, i_block_is_ac, i_block_seq_ok, i_synced} <= '0;
		{i_hysteresis_select, i_cause_present, i_bad_block_count} <= '0;
		{i_decode_mode, i_search_level_threshold} <= '0;
		i_if_ok <= 1'b1;
		i_bad_blocks_lose_limit <= 6'h04;
		i_level <= 4'hf;
		repeat (20) @(posedge i_clk_sys);
		i_resetn <= 1'b1;
		settle(2);
		t_irq();
		t_read();
		t_sync();
		t_blk();
		t_ifc();
		t_lev();
		win(1'b1, 1'b0, 1'b0);
		win(1'b1, 1'b1, 1'b1);
		win(1'b0, 1'b0, 1'b1);
		$display("t_win done");
		summarize();
	end
endmodule : test_radio_interrupt_flag_logic
